// >>> cmtf_defs.vh
`ifndef CMTF_DEFS_VH
`define CMTF_DEFS_VH

// register indices on the plain port
`define CMTF_ADDR_CTRL 4'h0
`define CMTF_ADDR_STAT 4'h1
`define CMTF_ADDR_LOOKUP 4'h2
`define CMTF_ADDR_TEST 4'h3
`define CMTF_ADDR_ID 4'h4
`define CMTF_ADDR_TXREQ 4'h5
`define CMTF_ADDR_RXBUF 4'h6

// control fields
`define CMTF_CTRL_MODE_LSB 0
`define CMTF_CTRL_MODE_MSB 1
`define CMTF_CTRL_SLEEP 2
`define CMTF_CTRL_RESET 8'h01

// operating mode requests
`define CMTF_MODE_OPER 2'h0
`define CMTF_MODE_RESET 2'h1
`define CMTF_MODE_HALT 2'h2

// status bits
`define CMTF_STAT_RESET 0
`define CMTF_STAT_HALT 1
`define CMTF_STAT_SLEEP 2
`define CMTF_STAT_TXBUSY 3
`define CMTF_STAT_RXBUSY 4

// test select encodings
`define CMTF_TEST_NORMAL 2'h0
`define CMTF_TEST_LISTEN 2'h1
`define CMTF_TEST_EXTLOOP 2'h2
`define CMTF_TEST_INTLOOP 2'h3

// frame shifter
`define CMTF_FRAME_BITS 6'h13
`define CMTF_ACK_BIT 6'h12
`define CMTF_BIT_TIME_NS 2000
`define CMTF_CLK_NS 20

`endif

// >>> cmtf_row_decode.v
`timescale 1ns/1ps
module cmtf_row_decode (
    input wire [2:0] stdIdLowerBits,
    output reg [7:0] rowMask
);
    always @* begin
        rowMask = 8'h00;
        rowMask[stdIdLowerBits] = 1'b1;
    end
endmodule

// >>> cmtf_can_mode_test.v
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "cmtf_defs.vh"
// Function
// - lookup read gives upper bits, one-hot row
// - id 6f4 reads column de, row bit 4
// - sleep gates engine clock, no activity
// - reset request waits for transmission end
// - halt request waits for frame end
// - status flags report current mode
// - sleep cancel returns to prior mode
// - listen-only receives, tx pin recessive, no start
// - listen-only dominant bits fed back internally
// - test select 01 selects listen-only
// - test select 10 selects external loop-back
// - external loop-back receives own frame via pin
// - self-test writes transmitted frames to rx buffer
// - self-test generates own acknowledge
// - test select 11 selects internal loop-back
// - internal loop-back ignores rx pin, tx recessive
// - received id loads lookup register, standard only
module cmtf_can_mode_test (
    input wire clk,
    input wire nrst,
    input wire [3:0] addr,
    input wire [15:0] wrData,
    input wire wrStb,
    input wire rdStb,
    output reg [15:0] rdData,
    input wire busRxPin,
    output reg busTxPin,
    output reg engineClkEn
);

    localparam integer BIT_CYCLES = `CMTF_BIT_TIME_NS / `CMTF_CLK_NS;
    localparam [2:0] ST_RESET = 3'h0;
    localparam [2:0] ST_HALT = 3'h1;
    localparam [2:0] ST_OPER = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h3;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser: three flops, change accepted when last two agree
    reg rxMeta_r;
    reg rxS2_r;
    reg rxS3_r;
    reg rxPin_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxMeta_r <= 1'b1;
            rxS2_r <= 1'b1;
            rxS3_r <= 1'b1;
            rxPin_r <= 1'b1;
        end else begin
            rxMeta_r <= busRxPin;
            rxS2_r <= rxMeta_r;
            rxS3_r <= rxS2_r;
            if (rxS2_r == rxS3_r) begin
                rxPin_r <= rxS3_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [1:0] modeReq_r;
    reg sleepReq_r;
    reg [1:0] loopTestSelect_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] preSleep_r;
    reg [10:0] rxId_r;
    reg [15:0] filterLookupReg_r;
    reg [15:0] rxBuf_r;
    reg rxBufFull_r;
    reg [10:0] txId_r;
    reg txReq_r;
    reg txBusy_r;
    reg rxBusy_r;
    reg [5:0] bitCnt_r;
    reg [6:0] tqCnt_r;
    reg [18:0] shift_r;
    reg [18:0] rxShift_r;
    reg engineTx_r;
    wire [7:0] rowMask;
    wire [15:0] statusWord;

    wire listenOnly = (loopTestSelect_r == `CMTF_TEST_LISTEN);
    wire extLoop = (loopTestSelect_r == `CMTF_TEST_EXTLOOP);
    wire intLoop = (loopTestSelect_r == `CMTF_TEST_INTLOOP);
    wire selfTest = extLoop | intLoop;
    wire running = (state_r == ST_OPER);
    wire bitTick = (tqCnt_r == BIT_CYCLES[6:0] - 7'h01);
    wire frameBusy = txBusy_r | rxBusy_r;

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OPER: begin
                // reset waits only for a transmit, halt for any frame
                if (modeReq_r == `CMTF_MODE_RESET && !txBusy_r) begin
                    state_nxt = ST_RESET;
                end else if (modeReq_r == `CMTF_MODE_HALT && !frameBusy) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_RESET, ST_HALT: begin
                if (sleepReq_r) begin
                    state_nxt = ST_SLEEP;
                end else if (modeReq_r == `CMTF_MODE_OPER) begin
                    state_nxt = ST_OPER;
                end else if (modeReq_r == `CMTF_MODE_HALT) begin
                    state_nxt = ST_HALT;
                end else begin
                    state_nxt = ST_RESET;
                end
            end
            ST_SLEEP: begin
                if (!sleepReq_r) begin
                    state_nxt = preSleep_r;
                end
            end
            default: state_nxt = ST_RESET;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RESET;
            preSleep_r <= ST_RESET;
            engineClkEn <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_SLEEP) begin
                preSleep_r <= state_r;
            end
            engineClkEn <= (state_nxt != ST_SLEEP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit engine; frozen outside operation, so sleep means no activity
    // simplified frame: sof, 11-bit id, pad, ack slot, eof marker
    wire txLine = listenOnly ? 1'b1 : engineTx_r;
    // internal loop-back uses the engine's bits alone, listen-only merges its dominant bits with the pin
    wire rxLine = intLoop ? engineTx_r
                : (listenOnly ? (rxPin_r & engineTx_r)
                : rxPin_r);
    wire ackSlot = (bitCnt_r == `CMTF_ACK_BIT);
    // own frames come back one bit late, since the engine samples its own sof as the first bit
    wire [10:0] frameId = txBusy_r ? rxShift_r[16:6] : rxShift_r[17:7];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tqCnt_r <= 7'h00;
            bitCnt_r <= 6'h00;
            txBusy_r <= 1'b0;
            rxBusy_r <= 1'b0;
            shift_r <= 19'h7ffff;
            rxShift_r <= 19'h00000;
            engineTx_r <= 1'b1;
            txReq_r <= 1'b0;
            rxId_r <= 11'h000;
            rxBufFull_r <= 1'b0;
            rxBuf_r <= 16'h0000;
        end else begin
            if (wrStb && addr == `CMTF_ADDR_TXREQ && wrData[0]) begin
                txReq_r <= 1'b1;
            end
            if (wrStb && addr == `CMTF_ADDR_RXBUF && !wrData[15]) begin
                rxBufFull_r <= 1'b0;
            end
            if (!running) begin
                tqCnt_r <= 7'h00;
                // reset may cut a reception: drop it and release the pin
                engineTx_r <= 1'b1;
                rxBusy_r <= 1'b0;
            end else if (bitTick) begin
                tqCnt_r <= 7'h00;
                if (!frameBusy) begin
                    engineTx_r <= 1'b1;
                    if (txReq_r && !listenOnly) begin
                        txBusy_r <= 1'b1;
                        txReq_r <= 1'b0;
                        shift_r <= {1'b0, txId_r, 7'h7f};
                        engineTx_r <= 1'b0;
                        bitCnt_r <= 6'h01;
                        rxShift_r <= 19'h00000;
                    end else if (!rxLine) begin
                        rxBusy_r <= 1'b1;
                        bitCnt_r <= 6'h01;
                        rxShift_r <= 19'h00000;
                    end
                end else begin
                    rxShift_r <= {rxShift_r[17:0], rxLine};
                    bitCnt_r <= bitCnt_r + 6'h01;
                    if (txBusy_r) begin
                        shift_r <= {shift_r[17:0], 1'b1};
                        // self-test drives its own acknowledge
                        engineTx_r <= (ackSlot && selfTest) ? 1'b0 : shift_r[17];
                    end else begin
                        // receivers acknowledge unless in plain listen wiring
                        engineTx_r <= ackSlot ? 1'b0 : 1'b1;
                    end
                    if (bitCnt_r == `CMTF_FRAME_BITS) begin
                        txBusy_r <= 1'b0;
                        rxBusy_r <= 1'b0;
                        engineTx_r <= 1'b1;
                        if (rxBusy_r || selfTest) begin
                            rxId_r <= frameId;
                            rxBufFull_r <= 1'b1;
                            rxBuf_r <= {5'h00, frameId};
                        end
                    end
                end
            end else begin
                tqCnt_r <= tqCnt_r + 7'h01;
            end
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busTxPin <= 1'b1;
        end else begin
            busTxPin <= intLoop ? 1'b1 : txLine;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // filter lookup decode
    cmtf_row_decode rowDec (
        .stdIdLowerBits(rxId_r[2:0]),
        .rowMask(rowMask)
    );

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filterLookupReg_r <= 16'h0000;
        end else begin
            filterLookupReg_r <= {rxId_r[10:3], rowMask};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port
    assign statusWord = {11'h000, rxBusy_r, txBusy_r,
                         state_r == ST_SLEEP, state_r == ST_HALT,
                         state_r == ST_RESET};

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeReq_r <= `CMTF_MODE_RESET;
            sleepReq_r <= 1'b0;
            loopTestSelect_r <= `CMTF_TEST_NORMAL;
            txId_r <= 11'h000;
            rdData <= 16'h0000;
        end else begin
            if (wrStb) begin
                case (addr)
                    `CMTF_ADDR_CTRL: begin
                        modeReq_r <= wrData[`CMTF_CTRL_MODE_MSB:`CMTF_CTRL_MODE_LSB];
                        sleepReq_r <= wrData[`CMTF_CTRL_SLEEP];
                    end
                    // host changes it only in halt; the block does not police it
                    `CMTF_ADDR_TEST: loopTestSelect_r <= wrData[1:0];
                    `CMTF_ADDR_ID: txId_r <= wrData[10:0];
                    default: ;
                endcase
            end
            rdData <= 16'h0000;
            if (rdStb) begin
                case (addr)
                    `CMTF_ADDR_CTRL: rdData <= {13'h0000, sleepReq_r, modeReq_r};
                    `CMTF_ADDR_STAT: rdData <= statusWord;
                    `CMTF_ADDR_LOOKUP: rdData <= filterLookupReg_r;
                    `CMTF_ADDR_TEST: rdData <= {14'h0000, loopTestSelect_r};
                    `CMTF_ADDR_ID: rdData <= {5'h00, txId_r};
                    `CMTF_ADDR_TXREQ: rdData <= {15'h0000, txReq_r};
                    `CMTF_ADDR_RXBUF: rdData <= {rxBufFull_r, rxBuf_r[14:0]};
                    default: rdData <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// >>> cmtf_props.sv
`timescale 1ns/1ps
module cmtf_props (
    input wire clk,
    input wire nrst,
    input wire [3:0] addr,
    input wire [15:0] wrData,
    input wire wrStb,
    input wire rdStb,
    input wire [15:0] rdData,
    input wire busRxPin,
    input wire busTxPin,
    input wire engineClkEn
);
    reg [1:0] testSel_r;
    // mirror of the test select field, since the pin rules hang on it
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            testSel_r <= 2'h0;
        else if (wrStb && addr == 4'h3)
            testSel_r <= wrData[1:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_look_rd; rdStb && addr == 4'h2; endsequence
    sequence s_stat_rd; rdStb && addr == 4'h1; endsequence
    sequence s_wake; wrStb && addr == 4'h0 && !wrData[2]; endsequence
    property p_look; s_look_rd |=> $onehot(rdData[7:0]); endproperty
    a_look: assert property (p_look) else $error("row not one-hot");
    property p_stat; s_stat_rd |=> !(rdData[0] && rdData[1]); endproperty
    a_stat: assert property (p_stat) else $error("two modes at once");
    property p_sleep; s_stat_rd |=> rdData[2] == !$past(engineClkEn); endproperty
    a_sleep: assert property (p_sleep) else $error("clock on in sleep");
    property p_quiet; !engineClkEn |-> busTxPin; endproperty
    a_quiet: assert property (p_quiet) else $error("pin active in sleep");
    property p_listen; (testSel_r == 2'h1) [*2] |-> busTxPin; endproperty
    a_listen: assert property (p_listen) else $error("listen pin dominant");
    property p_intloop; (testSel_r == 2'h3) [*2] |-> busTxPin; endproperty
    a_intloop: assert property (p_intloop) else $error("loop pin dominant");
    property p_wake; s_wake |-> ##[1:4] engineClkEn; endproperty
    a_wake: assert property (p_wake) else $error("clock not back");
    // in external loop-back a dominant bit lasts at least 8 cycles, never a glitch
    property p_sof; $fell(busTxPin) && testSel_r == 2'h2 |-> !busTxPin [*8]; endproperty
    a_sof: assert property (p_sof) else $error("short dominant bit");
endmodule
bind cmtf_can_mode_test cmtf_props cmtf_props_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .busRxPin(busRxPin), .busTxPin(busTxPin), .engineClkEn(engineClkEn));

// >>> cmtf_node.sv
`timescale 1ns/1ps
module cmtf_node (
    input wire clk,
    input wire txPin,
    input wire sendGo,
    input wire [10:0] sendId,
    input wire ackOn,
    output wire rxPin
);
    reg nodeTx_r = 1'b1;
    reg busy_r = 1'b0;
    integer i;
    // wired-and bus, recessive high when nobody drives
    assign rxPin = txPin & nodeTx_r;
    // sof, id msb first, then recessive tail; sender leaves ack slot recessive
    always @(posedge sendGo) begin
        busy_r = 1'b1;
        nodeTx_r <= 1'b0;
        repeat (100) @(posedge clk);
        for (i = 10; i >= 0; i = i - 1) begin
            nodeTx_r <= sendId[i];
            repeat (100) @(posedge clk);
        end
        nodeTx_r <= 1'b1;
        repeat (800) @(posedge clk);
        busy_r = 1'b0;
    end
    // ack a frame from the device; busy guard stops acking the device's own ack
    always @(negedge txPin) begin
        if (ackOn && !busy_r) begin
            repeat (1805) @(posedge clk);
            nodeTx_r <= 1'b0;
            repeat (100) @(posedge clk);
            nodeTx_r <= 1'b1;
        end
    end
endmodule

// >>> can_mode_test_filter_support_tb_top.sv
`timescale 1ns/1ps
module can_mode_test_filter_support_tb_top;
    reg clk, nrst, wrStb, rdStb, sendGo, ackOn, p;
    reg [3:0] addr;
    reg [15:0] wrData, d;
    reg [10:0] sendId, id;
    wire [15:0] rdData;
    wire busRxPin, busTxPin, engineClkEn;
    integer miscompares = 0, tests_run = 0, cyc = 0, k, n;
    cmtf_can_mode_test cmtf_can_mode_test_inst (.clk(clk), .nrst(nrst), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .busRxPin(busRxPin), .busTxPin(busTxPin), .engineClkEn(engineClkEn));
    cmtf_node cmtf_node_inst (.clk(clk), .txPin(busTxPin), .sendGo(sendGo),
        .sendId(sendId), .ackOn(ackOn), .rxPin(busRxPin));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task final_report;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task chk(input [15:0] g, input [15:0] e);
        tests_run = tests_run + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task wr(input [3:0] a, input [15:0] v);
        @(posedge clk);
        addr <= a;
        wrData <= v;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] m, input [15:0] e, input c);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdData;
        if (c)
            chk(d & m, e);
    endtask
    // status polls are bounded: a hung mode change must not stall the run
    task waitSt(input integer b, input v);
        n = 0;
        rd(4'h1, 16'h0, 16'h0, 1'b0);
        while (d[b] !== v && n < 1500) begin
            rd(4'h1, 16'h0, 16'h0, 1'b0);
            n = n + 1;
        end
        chk({15'h0, d[b]}, {15'h0, v});
    endtask
    task go(input [10:0] i);
        @(posedge clk);
        sendId <= i;
        sendGo <= 1'b1;
        @(posedge clk);
        sendGo <= 1'b0;
    endtask
    // p ends low if the pin went dominant at any edge of the window
    task watch(input integer c);
        p = 1'b1;
        repeat (c) begin
            @(posedge clk);
            p = p & busTxPin;
        end
    endtask
    task frame(input [10:0] i);
        go(i);
        watch(2000);
    endtask
    function [15:0] lk(input [10:0] i);
        lk = {i[10:3], 8'h01 << i[2:0]};
    endfunction
    initial begin
        {nrst, wrStb, rdStb, sendGo, addr, wrData, sendId, id, d} = 0;
        {ackOn, p} = 2'h3;
        k = $urandom(32'he19d8e12);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 16'hffff, 16'h0001, 1'b1);
        rd(4'h3, 16'hffff, 16'h0000, 1'b1);
        rd(4'h9, 16'hffff, 16'h0000, 1'b1);
        wr(4'h0, 16'h0000);
        waitSt(0, 1'b0);
        for (k = 0; k < 4; k = k + 1) begin
            id = (k == 0) ? 11'h6f4 : $urandom;
            frame(id);
            chk({15'h0, p}, 16'h0000);
            rd(4'h2, 16'hffff, lk(id), 1'b1);
        end
        $display("lookup test done");
        for (k = 1; k < 3; k = k + 1) begin
            id = $urandom;
            wr(4'h4, {5'h0, id});
            if (k == 1)
                wr(4'h5, 16'h0001);
            else
                go(id);
            // ask for the mode while the frame is still on the bus
            repeat (400) @(posedge clk);
            wr(4'h0, k[15:0]);
            rd(4'h1, 16'h0003, 16'h0000, 1'b1);
            waitSt(k - 1, 1'b1);
            rd(4'h2, 16'hffff, lk(id), k == 2);
            wr(4'h0, 16'h0000);
            waitSt(k - 1, 1'b0);
        end
        $display("mode test done");
        for (k = 1; k < 3; k = k + 1) begin
            wr(4'h0, k[15:0]);
            waitSt(k - 1, 1'b1);
            wr(4'h0, k[15:0] | 16'h0004);
            waitSt(2, 1'b1);
            chk({15'h0, engineClkEn}, 16'h0000);
            wr(4'h0, k[15:0]);
            waitSt(2, 1'b0);
            rd(4'h1, 16'h0003, k[15:0], 1'b1);
        end
        $display("sleep test done");
        ackOn <= 1'b0;
        for (k = 1; k < 4; k = k + 1) begin
            wr(4'h3, k[15:0]);
            wr(4'h6, 16'h7fff);
            wr(4'h0, 16'h0000);
            waitSt(1, 1'b0);
            id = $urandom;
            // listen-only gets no tx request from us
            if (k != 1) begin
                wr(4'h4, {5'h0, id});
                wr(4'h5, 16'h0001);
            end
            if (k == 2)
                watch(2100);
            else
                frame(k == 1 ? id : ~id);
            // only external loop-back may show its frame on the pin
            chk({15'h0, p}, {15'h0, k != 2});
            rd(4'h6, 16'h87ff, {5'h10, id}, 1'b1);
            rd(4'h2, 16'hffff, lk(id), 1'b1);
            wr(4'h0, 16'h0002);
            waitSt(1, 1'b1);
        end
        $display("test mode test done");
        final_report;
    end
endmodule
